// [common/smad_regs.vh]
`ifndef SMAD_REGS_VH
`define SMAD_REGS_VH
// Processor address layout
`define SMAD_A_W          16
`define SMAD_GRP_HI       15
`define SMAD_GRP_LO       13
`define SMAD_GRP_W        3
`define SMAD_SLOT_HI      12
`define SMAD_SLOT_LO      11
`define SMAD_LANE_BIT     10
`define SMAD_AUX_A_HI     10
`define SMAD_AUX_A_W      11
`define SMAD_COL_A_HI     9
`define SMAD_COL_A_W      10
`define SMAD_COL_DEPTH    1024
`define SMAD_AUX_DEPTH    2048
`define SMAD_DATA_W       16
`define SMAD_BYTE_W       8
`define SMAD_QUAL_W       3
// Slot codes
`define SMAD_SLOT_A       2'h0
`define SMAD_SLOT_B       2'h1
`define SMAD_SLOT_C       2'h2
`define SMAD_SLOT_NONE    2'h3
// FIFO
`define SMAD_FIFO_DEPTH   4
`define SMAD_FIFO_AW      2
`endif

// [verilog/smad_fifo.v]
`timescale 1ns/1ps
module smad_fifo #(
  parameter WIDTH = 26,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // Clock and reset
  input  wire             clock,
  input  wire             srst,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  // Honest full and empty from the occupancy count
  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage, no reset needed on data
  always @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap because depth is a power of two
  always @(posedge clock) begin
    if (srst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      case ({push, pop})
        2'b10:   count <= count + 1'b1;
        2'b01:   count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end
endmodule

// [verilog/smad_decoder.v]
`timescale 1ns/1ps
`include "smad_regs.vh"
module smad_decoder #(
  parameter [`SMAD_GRP_W-1:0] BOARD_GROUP = 3'h1
) (
  // Clock and reset
  input  wire                      clock,
  input  wire                      srst,
  // Processor bus
  input  wire [`SMAD_A_W-1:0]      cpu_addr,
  input  wire                      cpu_strobe,
  input  wire                      read_write_command,
  input  wire                      io_not_mem,
  input  wire                      main_aux_select,
  input  wire [`SMAD_BYTE_W-1:0]   cpu_data_in,
  output reg  [`SMAD_BYTE_W-1:0]   cpu_data_out,
  output reg                       cpu_data_oe_n,
  // Mode and straps
  input  wire                      slot_id_second,
  input  wire                      slot_id_third,
  input  wire                      setup_mode,
  // Collection side
  input  wire [`SMAD_COL_A_W-1:0]  collect_address,
  input  wire                      collect_write_n,
  input  wire [`SMAD_DATA_W-1:0]   pipe_data,
  output reg                       pipe_ready,
  // Qualifiers
  input  wire [`SMAD_QUAL_W-1:0]   pod_qualifier,
  input  wire                      external_qualifier,
  input  wire                      link_trigger_in,
  output reg  [`SMAD_QUAL_W-1:0]   qualifier_out,
  // Access control outputs, active low except slot_hit
  output reg                       high_byte_read_enable_n,
  output reg                       low_byte_enable_n,
  output reg                       aux_output_enable_n,
  output reg                       read_all_main_memory_n,
  output reg                       aux_chip_select_n,
  output reg                       aux_write_strobe_n,
  output reg                       setup_buffer_enable_n,
  output reg                       pipe_output_enable_n,
  output reg                       slot_hit
);
  localparam ST_IDLE  = 3'h1;
  localparam ST_READ  = 3'h2;
  localparam ST_WRITE = 3'h4;

  reg [`SMAD_DATA_W-1:0]  col_mem [0:`SMAD_COL_DEPTH-1];
  reg [`SMAD_BYTE_W-1:0]  aux_mem [0:`SMAD_AUX_DEPTH-1];
  reg [2:0]               state;
  reg [2:0]               next_state;
  reg [1:0]               slot;
  reg                     slot_valid;
  reg [2:0]               sid_b;
  reg [2:0]               sid_c;
  reg [2:0]               ext_s;
  reg [2:0]               lnk_s;
  reg [2:0]               pod0_s;
  reg [2:0]               pod1_s;
  reg [2:0]               pod2_s;
  reg                     ext_q;
  reg                     lnk_q;
  reg [`SMAD_QUAL_W-1:0]  pod_q;
  reg                     dec_hit;
  reg                     dec_rd;
  reg                     dec_wr;
  reg                     dec_hi;
  reg                     dec_lo;
  reg                     dec_aux_rd;
  reg                     dec_aux_wr;
  reg                     dec_main_rd;
  wire                    fifo_valid;
  wire                    cap_push;
  wire                    cap_pop;
  reg [`SMAD_FIFO_AW:0]   fill;
  reg [`SMAD_FIFO_AW:0]   next_fill;
  wire [`SMAD_COL_A_W+`SMAD_DATA_W-1:0] fifo_data;

  // Slot from the two straps; both high means unplugged
  function [1:0] slot_code;
    input b;
    input c;
    begin
      case ({c, b})
        2'b00:   slot_code = `SMAD_SLOT_A;
        2'b01:   slot_code = `SMAD_SLOT_B;
        2'b10:   slot_code = `SMAD_SLOT_C;
        default: slot_code = `SMAD_SLOT_NONE;
      endcase
    end
  endfunction

  // Pin synchronisers; third and second must agree to count
  always @(posedge clock) begin
    if (srst) begin
      sid_b  <= 3'h7;
      sid_c  <= 3'h7;
      ext_s  <= 3'h0;
      lnk_s  <= 3'h0;
      pod0_s <= 3'h0;
      pod1_s <= 3'h0;
      pod2_s <= 3'h0;
    end else begin
      sid_b  <= {sid_b[1:0], slot_id_second};
      sid_c  <= {sid_c[1:0], slot_id_third};
      ext_s  <= {ext_s[1:0], external_qualifier};
      lnk_s  <= {lnk_s[1:0], link_trigger_in};
      pod0_s <= {pod0_s[1:0], pod_qualifier[0]};
      pod1_s <= {pod1_s[1:0], pod_qualifier[1]};
      pod2_s <= {pod2_s[1:0], pod_qualifier[2]};
    end
  end

  // Filtered levels and the strapped slot
  always @(posedge clock) begin
    if (srst) begin
      ext_q      <= 1'b0;
      lnk_q      <= 1'b0;
      pod_q      <= 3'h0;
      slot       <= `SMAD_SLOT_NONE;
      slot_valid <= 1'b0;
    end else begin
      if (ext_s[2] == ext_s[1]) ext_q <= ext_s[2];
      if (lnk_s[2] == lnk_s[1]) lnk_q <= lnk_s[2];
      if (pod0_s[2] == pod0_s[1]) pod_q[0] <= pod0_s[2];
      if (pod1_s[2] == pod1_s[1]) pod_q[1] <= pod1_s[2];
      if (pod2_s[2] == pod2_s[1]) pod_q[2] <= pod2_s[2];
      if ((sid_b[2] == sid_b[1]) && (sid_c[2] == sid_c[1])) begin
        slot       <= slot_code(sid_b[2], sid_c[2]);
        slot_valid <= (slot_code(sid_b[2], sid_c[2]) != `SMAD_SLOT_NONE);
      end
    end
  end

  // Qualifier routing: own pod, then shared external and link
  always @(posedge clock) begin
    if (srst) begin
      qualifier_out <= 3'h0;
    end else begin
      qualifier_out <= {lnk_q, ext_q, pod_q[(slot == `SMAD_SLOT_NONE) ? `SMAD_SLOT_A : slot]};
    end
  end

  // Access decode; strobe comes from the same clock domain
  always @* begin
    dec_hit     = cpu_strobe & ~io_not_mem
                & (cpu_addr[`SMAD_GRP_HI:`SMAD_GRP_LO] == BOARD_GROUP)
                & slot_valid
                & (cpu_addr[`SMAD_SLOT_HI:`SMAD_SLOT_LO] == slot);
    dec_rd      = dec_hit & read_write_command;
    dec_wr      = dec_hit & ~read_write_command;
    dec_hi      = cpu_addr[`SMAD_LANE_BIT];
    dec_lo      = ~cpu_addr[`SMAD_LANE_BIT];
    dec_main_rd = dec_rd & main_aux_select;
    dec_aux_rd  = dec_rd & ~main_aux_select;
    dec_aux_wr  = dec_wr & ~main_aux_select;
  end

  // Bus handshake: one access at a time, released when strobe drops
  always @* begin
    case (state)
      ST_IDLE: begin
        if (dec_rd) next_state = ST_READ;
        else if (dec_wr) next_state = ST_WRITE;
        else next_state = ST_IDLE;
      end
      ST_READ:  next_state = cpu_strobe ? ST_READ : ST_IDLE;
      ST_WRITE: next_state = cpu_strobe ? ST_WRITE : ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  always @(posedge clock) begin
    if (srst) state <= ST_IDLE;
    else state <= next_state;
  end

  // Registered enables; high and low byte decode opposite lane bit values, so drivers stay exclusive
  always @(posedge clock) begin
    if (srst) begin
      high_byte_read_enable_n <= 1'b1;
      low_byte_enable_n       <= 1'b1;
      aux_output_enable_n     <= 1'b1;
      read_all_main_memory_n  <= 1'b1;
      aux_chip_select_n       <= 1'b1;
      aux_write_strobe_n      <= 1'b1;
      slot_hit                <= 1'b0;
    end else begin
      high_byte_read_enable_n <= ~(dec_main_rd & dec_hi);
      low_byte_enable_n       <= ~((dec_main_rd | dec_aux_rd | dec_aux_wr) & dec_lo);
      aux_output_enable_n     <= ~dec_aux_rd;
      read_all_main_memory_n  <= ~dec_main_rd;
      aux_chip_select_n       <= ~(dec_aux_rd | dec_aux_wr);
      aux_write_strobe_n      <= ~dec_aux_wr;
      slot_hit                <= dec_hit;
    end
  end

  // Pipeline released from the memory while reading; setup latches in setup
  always @(posedge clock) begin
    if (srst) begin
      pipe_output_enable_n  <= 1'b1;
      setup_buffer_enable_n <= 1'b1;
    end else begin
      pipe_output_enable_n  <= dec_main_rd | setup_mode;
      setup_buffer_enable_n <= ~setup_mode;
    end
  end

  // Capture handshake; a word is taken only while the queue has room
  assign cap_push = ~collect_write_n & ~setup_mode & pipe_ready;
  assign cap_pop  = fifo_valid & read_all_main_memory_n;

  // Queue fill mirrored here so pipe_ready leaves a flip-flop
  always @* begin
    case ({cap_push, cap_pop})
      2'b10:   next_fill = fill + 1'b1;
      2'b01:   next_fill = fill - 1'b1;
      default: next_fill = fill;
    endcase
  end

  // Ready looks one edge ahead, so it never lags the queue by a word
  always @(posedge clock) begin
    if (srst) begin
      fill       <= {(`SMAD_FIFO_AW+1){1'b0}};
      pipe_ready <= 1'b1;
    end else begin
      fill       <= next_fill;
      pipe_ready <= (next_fill != `SMAD_FIFO_DEPTH);
    end
  end

  // Capture words queue so a read cycle cannot lose a strobe
  smad_fifo #(
    .WIDTH(`SMAD_COL_A_W + `SMAD_DATA_W),
    .DEPTH(`SMAD_FIFO_DEPTH),
    .AW   (`SMAD_FIFO_AW)
  ) u_fifo (
    .clock    (clock),
    .srst     (srst),
    .in_valid (cap_push),
    .in_ready (),
    .in_data  ({collect_address, pipe_data}),
    .out_valid(fifo_valid),
    .out_ready(read_all_main_memory_n),
    .out_data (fifo_data)
  );

  // Collection memory: one 16 bit word per drained strobe
  always @(posedge clock) begin
    if (cap_pop) begin
      col_mem[fifo_data[`SMAD_COL_A_W+`SMAD_DATA_W-1:`SMAD_DATA_W]] <=
        fifo_data[`SMAD_DATA_W-1:0];
    end
  end

  // Aux memory addressed straight from the processor bus
  always @(posedge clock) begin
    if (dec_aux_wr & dec_lo & (state == ST_IDLE)) begin
      aux_mem[cpu_addr[`SMAD_AUX_A_HI:0]] <= cpu_data_in;
    end
  end

  // Read data and transmit-direction drive; one source per access
  always @(posedge clock) begin
    if (srst) begin
      cpu_data_out  <= 8'h00;
      cpu_data_oe_n <= 1'b1;
    end else begin
      cpu_data_oe_n <= ~dec_rd;
      if (dec_aux_rd) begin
        cpu_data_out <= aux_mem[cpu_addr[`SMAD_AUX_A_HI:0]];
      end else if (dec_main_rd & dec_hi) begin
        cpu_data_out <= col_mem[cpu_addr[`SMAD_COL_A_HI:0]][`SMAD_DATA_W-1:`SMAD_BYTE_W];
      end else if (dec_main_rd) begin
        cpu_data_out <= col_mem[cpu_addr[`SMAD_COL_A_HI:0]][`SMAD_BYTE_W-1:0];
      end else begin
        cpu_data_out <= 8'h00;
      end
    end
  end
endmodule

// [dv/smad_props.sv]
`timescale 1ns/1ps
`include "smad_regs.vh"
module smad_props #(
  parameter [`SMAD_GRP_W-1:0] BOARD_GROUP = 3'h1
) (
  // Clock, reset, processor side
  input wire                 clock,
  input wire                 srst,
  input wire [`SMAD_A_W-1:0] cpu_addr,
  input wire                 cpu_strobe,
  input wire                 read_write_command,
  input wire                 io_not_mem,
  input wire                 main_aux_select,
  input wire                 cpu_data_oe_n,
  // Enables
  input wire                 high_byte_read_enable_n,
  input wire                 low_byte_enable_n,
  input wire                 aux_output_enable_n,
  input wire                 read_all_main_memory_n,
  input wire                 aux_chip_select_n,
  input wire                 aux_write_strobe_n,
  input wire                 pipe_output_enable_n
);
  // All six access enables idle; pipeline and setup enables not included
  wire idle = high_byte_read_enable_n & low_byte_enable_n & aux_output_enable_n
              & read_all_main_memory_n & aux_chip_select_n & aux_write_strobe_n;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Enables are tied to the request seen one edge earlier, and to each other in the same cycle
  a_group_miss: assert property (cpu_strobe && cpu_addr[15:13] != BOARD_GROUP |=> idle)
    else $error("enable on foreign group");
  a_io_ignored: assert property (cpu_strobe && io_not_mem |=> idle)
    else $error("enable on io access");
  a_strobe_gone: assert property (!cpu_strobe |=> idle && cpu_data_oe_n)
    else $error("enable without strobe");
  a_high_main: assert property (!high_byte_read_enable_n |-> $past(main_aux_select && cpu_addr[10]))
    else $error("high byte lane misused");
  a_low_lane: assert property (!low_byte_enable_n |-> !$past(cpu_addr[10]))
    else $error("low lane on high address");
  a_aux_oe_rd: assert property (!aux_output_enable_n |-> $past(read_write_command && !main_aux_select))
    else $error("aux output on non read");
  a_aux_we_cs: assert property (!aux_write_strobe_n |-> !aux_chip_select_n && $past(!read_write_command))
    else $error("aux write strobe misused");
  a_read_all: assert property (!read_all_main_memory_n |-> $past(read_write_command && main_aux_select))
    else $error("read all on wrong access");
  a_pipe_off: assert property (!read_all_main_memory_n |-> pipe_output_enable_n)
    else $error("pipeline drives during read");
  a_one_driver: assert property (high_byte_read_enable_n || low_byte_enable_n)
    else $error("two bus drivers");
endmodule
bind smad_decoder smad_props #(.BOARD_GROUP(BOARD_GROUP)) u_props (.clock, .srst, .cpu_addr, .cpu_strobe,
  .read_write_command, .io_not_mem, .main_aux_select, .cpu_data_oe_n, .high_byte_read_enable_n,
  .low_byte_enable_n, .aux_output_enable_n, .read_all_main_memory_n, .aux_chip_select_n,
  .aux_write_strobe_n, .pipe_output_enable_n);

// [dv/smad_ctl_model.sv]
`timescale 1ns/1ps
module smad_ctl_model (
  // Clock, reset, request
  input wire        clock,
  input wire        srst,
  input wire        go,
  input wire [3:0]  n_words,
  // Capture handshake
  input wire        pipe_ready,
  output reg [9:0]  collect_address,
  output reg        collect_write_n,
  output reg [15:0] pipe_data
);
  reg [9:0] next_addr;
  reg [3:0] left;
  // Counter addresses; a refused word stays put until taken
  always @(posedge clock) begin
    if (srst) begin
      next_addr       <= 10'h000;
      left            <= 4'h0;
      collect_write_n <= 1'b1;
      collect_address <= 10'h000;
      pipe_data       <= 16'h0000;
    end else if (go) begin
      left <= n_words;
    end else if (!collect_write_n && !pipe_ready) begin
      left <= left;
    end else if (left != 4'h0) begin
      collect_write_n <= 1'b0;
      collect_address <= next_addr;
      pipe_data       <= {next_addr[7:0] ^ 8'h5a, next_addr[7:0]};
      next_addr       <= next_addr + 10'h001;
      left            <= left - 4'h1;
    end else begin
      collect_write_n <= 1'b1;
      collect_address <= ~collect_address; // Stale lines must not look valid
      pipe_data       <= ~pipe_data;
    end
  end
endmodule

// [dv/tb_state_memory_access_decoder.sv]
`timescale 1ns/1ps
module tb_state_memory_access_decoder;
  reg  [15:0] cpu_addr;
  reg  [7:0]  cpu_data_in;
  reg  [2:0]  pod_qualifier;
  reg         clock, srst, cpu_strobe, read_write_command, io_not_mem, main_aux_select;
  reg         setup_mode, external_qualifier, link_trigger_in, go, seen_full, slot_id_second, slot_id_third;
  wire [7:0]  cpu_data_out;
  wire [9:0]  collect_address;
  wire [15:0] pipe_data;
  wire [2:0]  qualifier_out;
  wire        cpu_data_oe_n, collect_write_n, pipe_ready, high_byte_read_enable_n, low_byte_enable_n;
  wire        aux_output_enable_n, read_all_main_memory_n, aux_chip_select_n, aux_write_strobe_n;
  wire        setup_buffer_enable_n, pipe_output_enable_n, slot_hit;
  reg  [5:0]  got_en;
  reg  [7:0]  got_d;
  reg         got_oe, got_hit, got_pipe;
  integer     n_errors, cmp_count, cycles, i;
  smad_decoder #(.BOARD_GROUP(3'h1)) dut (.clock, .srst, .cpu_addr, .cpu_strobe, .read_write_command,
    .io_not_mem, .main_aux_select, .cpu_data_in, .cpu_data_out, .cpu_data_oe_n, .slot_id_second,
    .slot_id_third, .setup_mode, .collect_address, .collect_write_n, .pipe_data, .pipe_ready,
    .pod_qualifier, .external_qualifier, .link_trigger_in, .qualifier_out, .high_byte_read_enable_n,
    .low_byte_enable_n, .aux_output_enable_n, .read_all_main_memory_n, .aux_chip_select_n,
    .aux_write_strobe_n, .setup_buffer_enable_n, .pipe_output_enable_n, .slot_hit);
  smad_ctl_model u_ctl (.clock, .srst, .go, .n_words(4'h6), .pipe_ready, .collect_address,
    .collect_write_n, .pipe_data);
  // Local sample clock for this slot
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task wrap_up;
    begin
      if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // One bus access held two cycles, then an idle cycle
  task cpu_io(input [15:0] a, input rw, input mn, input io, input [7:0] d);
    begin
      @(negedge clock);
      cpu_addr = a;
      read_write_command = rw;
      main_aux_select = mn;
      io_not_mem = io;
      cpu_data_in = d;
      cpu_strobe = 1'b1;
      @(negedge clock);
      got_en = {high_byte_read_enable_n, low_byte_enable_n, aux_output_enable_n,
                read_all_main_memory_n, aux_chip_select_n, aux_write_strobe_n};
      got_d = cpu_data_out;
      got_oe = cpu_data_oe_n;
      got_hit = slot_hit;
      got_pipe = pipe_output_enable_n;
      @(negedge clock);
      cpu_strobe = 1'b0;
      cpu_data_in = ~d;
      @(negedge clock);
    end
  endtask
  // Capture six words while a main read stalls the drain
  task t_capture;
    begin
      @(negedge clock);
      cpu_addr = 16'h2000;
      read_write_command = 1'b1;
      main_aux_select = 1'b1;
      cpu_strobe = 1'b1;
      go = 1'b1;
      @(negedge clock);
      go = 1'b0;
      seen_full = 1'b0;
      repeat (12) begin
        @(negedge clock);
        if (pipe_ready === 1'b0) seen_full = 1'b1;
      end
      chk(seen_full, 1'b1);
      cpu_strobe = 1'b0;
      repeat (12) @(negedge clock);
    end
  endtask
  task t_readback;
    for (i = 0; i < 6; i = i + 1) begin
      cpu_io(16'h2400 + i[15:0], 1'b1, 1'b1, 1'b0, 8'h00);
      chk(got_en, 6'h1b);
      chk(got_d, i[7:0] ^ 8'h5a);
      chk(got_oe, 1'b0);
      chk({got_hit, got_pipe}, 2'b11);
      cpu_io(16'h2000 + i[15:0], 1'b1, 1'b1, 1'b0, 8'h00);
      chk(got_en, 6'h2b);
      chk(got_d, i[7:0]);
    end
  endtask
  // Save two main bytes into aux, then read them back
  task t_aux;
    for (i = 0; i < 2; i = i + 1) begin
      cpu_io(16'h2000 + i[15:0], 1'b1, 1'b1, 1'b0, 8'h00);
      cpu_io(16'h2000 + i[15:0], 1'b0, 1'b0, 1'b0, got_d);
      chk(got_en, 6'h2c);
      chk(got_oe, 1'b1);
      chk({got_hit, got_pipe}, 2'b10);
      cpu_io(16'h2000 + i[15:0], 1'b1, 1'b0, 1'b0, 8'h00);
      chk(got_en, 6'h25);
      chk({got_oe, got_d}, {1'b0, i[7:0]});
    end
  endtask
  task t_refuse;
    begin
      cpu_io(16'h2800, 1'b1, 1'b1, 1'b0, 8'h00);
      chk({got_oe, got_en}, 7'h7f);
      chk({got_hit, got_pipe}, 2'b00);
      cpu_io(16'h4000, 1'b1, 1'b1, 1'b0, 8'h00);
      chk({got_oe, got_en}, 7'h7f);
      cpu_io(16'h2000, 1'b1, 1'b1, 1'b1, 8'h00);
      chk({got_oe, got_en}, 7'h7f);
    end
  endtask
  task t_setup;
    begin
      setup_mode = 1'b1;
      repeat (4) @(negedge clock);
      chk(setup_buffer_enable_n, 1'b0);
      chk(pipe_output_enable_n, 1'b1);
      setup_mode = 1'b0;
      repeat (4) @(negedge clock);
      chk(setup_buffer_enable_n, 1'b1);
      chk(pipe_output_enable_n, 1'b0);
    end
  endtask
  task t_qual(input [2:0] pod, input e, input l, input [2:0] exp);
    begin
      pod_qualifier = pod;
      external_qualifier = e;
      link_trigger_in = l;
      repeat (6) @(negedge clock);
      chk(qualifier_out, exp);
    end
  endtask
  // Restrap as slot B: only its own addresses and pod count
  task t_slot;
    begin
      slot_id_second = 1'b1;
      repeat (6) @(negedge clock);
      cpu_io(16'h2000, 1'b1, 1'b1, 1'b0, 8'h00);
      chk({got_oe, got_en}, 7'h7f);
      cpu_io(16'h2800, 1'b1, 1'b1, 1'b0, 8'h00);
      chk({got_oe, got_en}, 7'h2b);
      chk({got_hit, got_d}, 9'h100);
      t_qual(3'b010, 1'b0, 1'b0, 3'b001);
    end
  endtask
  // Hang guard
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      n_errors = n_errors + 1;
      wrap_up;
    end
  end
  initial begin
    {cpu_addr, cpu_data_in, pod_qualifier} = 27'h0;
    {cpu_strobe, read_write_command, io_not_mem, main_aux_select} = 4'h0;
    {setup_mode, external_qualifier, link_trigger_in, go, seen_full, slot_id_second, slot_id_third} = 7'h0;
    n_errors = 0;
    cmp_count = 0;
    cycles = 0;
    srst = 1'b1;
    repeat (6) @(negedge clock);
    srst = 1'b0;
    repeat (5) @(negedge clock);
    t_capture;
    t_readback;
    t_aux;
    t_refuse;
    t_setup;
    t_qual(3'b110, 1'b1, 1'b0, 3'b010);
    t_qual(3'b001, 1'b0, 1'b1, 3'b101);
    t_slot;
    wrap_up;
  end
endmodule
